// >>> hdl/ppa_pkg.sv
// constants shared by the secondary bus arbiter and its register file
// assumes a byte-addressed register port with config and memory spaces
// Overview of operation
// RL1: six externals and the bridge; classic, timed, preemptive
// RL2: reset gives classic arbitration with all windows off
// RL3: two classic tiers; bridge high, externals low by default
// RL4: classic control bit 7 parks the idle bus
// RL5: six mask bits block their external requests
// RL6: watch on: no response within 16 clocks flags a timeout
// RL7: auto-mask blocks silent masters; clearing it drops them
// RL8: one timeout status bit per external master
// RL9: timed mode grants from a 128-phase table, one entry per phase
// RL10: software and working tables; grants use the working one
// RL11: a one to the load bit copies the software table inward
// RL12: status reads one while the software table is unloaded
// RL13: each phase holds a 4-bit port number
// RL14: software gives a port at least three consecutive phases
// RL15: port 0 is the bridge, 1 to 6 externals, 7 to 15 reserved
// RL16: software sets timed enable and scheme select for timed mode
// RL17: select bits 19:17 at 100b pick weighted round robin
// RL18: software table is sixteen words from 1c0h to 1fch, 4-bit entries
// RL19: preemptive mode stops the bus owner at a phase event
// RL20: software adds the preemptive bit to the timed setup
// RL21: four windows tag upstream memory accesses with a class
// RL22: window control bits 3:1 enable, bit 0 holds the class tag
// RL23: window 0 control, base, limit at 08h, 0ch, 10h; others follow
// RL24: software keeps base, limit word aligned, limit above base
// RL25: tagged traffic still travels on channel zero
// RL26: an address is inside when base <= address <= limit
package ppa_pkg;
    localparam int          NUM_EXT        = 6;
    localparam int          NUM_PHASE      = 128;
    localparam int          TAB_WORDS      = 16;
    localparam int          NUM_WIN        = 4;
    // config space byte offsets
    localparam logic [11:0] CFG_ARB_DW     = 12'h0dc;
    localparam logic [11:0] CFG_CLASSIC    = 12'h0dc;
    localparam logic [11:0] CFG_MASK       = 12'h0dd;
    localparam logic [11:0] CFG_TO_STAT    = 12'h0de;
    localparam logic [11:0] CFG_CH1_CTRL   = 12'h170;
    localparam logic [11:0] CFG_CH1_DW     = 12'h174;
    localparam logic [11:0] CFG_CH1_STAT   = 12'h176;
    localparam logic [11:0] CFG_TAB_FIRST  = 12'h1c0;
    localparam logic [11:0] CFG_TAB_LAST   = 12'h1fc;
    // memory window byte offsets
    localparam logic [11:0] MEM_ISO_CTRL   = 12'h004;
    localparam logic [11:0] MEM_WIN0_CTRL  = 12'h008;
    localparam logic [11:0] MEM_WIN0_BASE  = 12'h00c;
    localparam logic [11:0] MEM_WIN0_LIM   = 12'h010;
    localparam logic [11:0] MEM_WIN_STRIDE = 12'h00c;
    // field positions
    localparam int          CLS_PARK_BIT   = 7;
    localparam int          MSK_WATCH_BIT  = 7;
    localparam int          MSK_AUTO_BIT   = 6;
    localparam int          ISO_TIMED_BIT  = 1;
    localparam int          ISO_PREEMP_BIT = 2;
    localparam int          SEL_LO         = 17;
    localparam int          LOAD_BIT       = 16;
    localparam int          TABST_BIT      = 16;
    localparam logic [2:0]  SEL_WRR128     = 3'h4;
    localparam int          WIN_EN_LO      = 1;
    localparam int          WIN_TC_BIT     = 0;
    // reset values
    localparam logic [7:0]  CLASSIC_RST    = 8'h81;
    localparam logic [7:0]  MASK_RST       = 8'h00;
    localparam logic [31:0] ISO_RST        = 32'h0000_0000;
    localparam logic [3:0]  WIN_CTRL_RST   = 4'h0;
    localparam logic [2:0]  SEL_RST        = 3'h0;
    // timing in bus clocks
    localparam int          NO_RESP_CLKS   = 16;
    localparam int          PHASE_CLKS     = 8;
    typedef enum logic [1:0] {ST_IDLE, ST_GRANT, ST_BUSY, ST_STOP} ppa_st_e;
endpackage

// >>> hdl/ppa_arbiter.sv
// secondary bus arbiter with time-based schedule and class windows
// registers on clk; arbitration on the bus clock pci_clk
`timescale 1ns/1ps
module ppa_arbiter
    import ppa_pkg::*;
#(
    parameter int PHASE_LEN = PHASE_CLKS
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        pci_clk,
    input  wire logic        reg_cfg_sel,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [3:0]  reg_be,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        int_req,
    output logic             int_gnt,
    input  wire logic [5:0]  ext_req_n,
    output logic      [5:0]  ext_gnt_n,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic        up_valid,
    input  wire logic [31:0] up_addr,
    output logic             up_tvalid,
    output logic      [2:0]  up_tc,
    output logic      [2:0]  up_vc
);
    localparam int SYNW = 19;

    logic [7:0]  classic_r;
    logic [7:0]  mask_r;
    logic [31:0] iso_r;
    logic [2:0]  sel_r;
    logic [3:0]  wctl_r  [NUM_WIN];
    logic [31:0] wbase_r [NUM_WIN];
    logic [31:0] wlim_r  [NUM_WIN];
    logic [31:0] ctab_r  [TAB_WORDS];
    logic [31:0] stab_r  [TAB_WORDS];
    logic        pend_r;
    logic        ld_tgl_r;
    logic        ld_busy_r;
    logic [6:0]  back_s1_r;
    logic [6:0]  back_s2_r;
    logic        ack_seen_r;
    logic [6:0]  bk_r;
    logic [31:0] rd_nxt;
    logic        tab_wr;
    logic        ld_go;
    logic        ld_done;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [11:0] waddr(input int w, input logic [11:0] o);
        return o + 12'(w) * MEM_WIN_STRIDE;
    endfunction

    wire cfg_wr = reg_wr & reg_cfg_sel;
    wire mem_wr = reg_wr & ~reg_cfg_sel;
    wire [11:0] dw = {reg_addr[11:2], 2'b00};

    // classic control and request mask bytes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            classic_r <= CLASSIC_RST; // RL2 RL3 RL4
            mask_r    <= MASK_RST;
        end else if (cfg_wr && dw == CFG_ARB_DW) begin
            if (reg_be[0]) classic_r <= reg_wdata[7:0];
            if (reg_be[1]) mask_r    <= reg_wdata[15:8];
        end
    end

    // scheme select and table load strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_r <= SEL_RST;
        end else if (cfg_wr && dw == CFG_CH1_CTRL && reg_be[2]) begin
            sel_r <= reg_wdata[SEL_LO +: 3]; // RL17
        end
    end
    assign ld_go = cfg_wr && dw == CFG_CH1_CTRL && reg_be[2]
                   && reg_wdata[LOAD_BIT] && !ld_busy_r; // RL11

    // software copy of the schedule table
    assign tab_wr = cfg_wr && dw >= CFG_TAB_FIRST && dw <= CFG_TAB_LAST;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < TAB_WORDS; i++) ctab_r[i] <= 32'h0;
        end else if (tab_wr) begin
            ctab_r[reg_addr[5:2]] <= merge(ctab_r[reg_addr[5:2]],
                                           reg_wdata, reg_be); // RL18 RL13
        end
    end

    // staged copy held steady while the bus domain takes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < TAB_WORDS; i++) stab_r[i] <= 32'h0;
            ld_tgl_r  <= 1'b0;
            ld_busy_r <= 1'b0;
        end else if (ld_go) begin
            for (int i = 0; i < TAB_WORDS; i++) stab_r[i] <= ctab_r[i];
            ld_tgl_r  <= ~ld_tgl_r;
            ld_busy_r <= 1'b1;
        end else if (ld_done) begin
            ld_busy_r <= 1'b0;
        end
    end

    // unloaded-table flag; a table write beats a load in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_r <= 1'b0;
        end else if (tab_wr) begin
            pend_r <= 1'b1; // RL12
        end else if (ld_go) begin
            pend_r <= 1'b0; // RL12
        end
    end

    // isochrony control and class windows
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            iso_r <= ISO_RST;
            for (int w = 0; w < NUM_WIN; w++) begin
                wctl_r[w]  <= WIN_CTRL_RST; // RL2
                wbase_r[w] <= 32'h0;
                wlim_r[w]  <= 32'h0;
            end
        end else if (mem_wr) begin
            if (dw == MEM_ISO_CTRL) iso_r <= merge(iso_r, reg_wdata, reg_be);
            for (int w = 0; w < NUM_WIN; w++) begin
                if (dw == waddr(w, MEM_WIN0_CTRL) && reg_be[0])
                    wctl_r[w] <= reg_wdata[3:0]; // RL22 RL23
                if (dw == waddr(w, MEM_WIN0_BASE))
                    wbase_r[w] <= merge(wbase_r[w], reg_wdata, reg_be);
                if (dw == waddr(w, MEM_WIN0_LIM))
                    wlim_r[w] <= merge(wlim_r[w], reg_wdata, reg_be);
            end
        end
    end

    // status back from the bus domain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            back_s1_r  <= 7'h0;
            back_s2_r  <= 7'h0;
            ack_seen_r <= 1'b0;
        end else begin
            back_s1_r  <= bk_r;
            back_s2_r  <= back_s1_r;
            ack_seen_r <= back_s2_r[6];
        end
    end
    assign ld_done = ld_busy_r && (back_s2_r[6] ^ ack_seen_r);

    // register read mux
    always_comb begin
        rd_nxt = 32'h0;
        if (reg_cfg_sel) begin
            if (dw == CFG_ARB_DW)
                rd_nxt = {8'h0, 2'b00, back_s2_r[5:0], mask_r, classic_r}; // RL8
            else if (dw == CFG_CH1_CTRL)
                rd_nxt = {12'h0, sel_r, 17'h0};
            else if (dw == CFG_CH1_DW)
                rd_nxt = {15'h0, pend_r, 16'h0}; // RL12
            else if (dw >= CFG_TAB_FIRST && dw <= CFG_TAB_LAST)
                rd_nxt = ctab_r[reg_addr[5:2]];
        end else begin
            if (dw == MEM_ISO_CTRL) rd_nxt = iso_r;
            for (int w = 0; w < NUM_WIN; w++) begin
                if (dw == waddr(w, MEM_WIN0_CTRL)) rd_nxt = {28'h0, wctl_r[w]};
                if (dw == waddr(w, MEM_WIN0_BASE)) rd_nxt = wbase_r[w];
                if (dw == waddr(w, MEM_WIN0_LIM))  rd_nxt = wlim_r[w];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= 32'h0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_nxt;
        end
    end

    // class window tagging; lowest window wins on overlap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_tvalid <= 1'b0;
            up_tc     <= 3'h0;
        end else begin
            up_tvalid <= up_valid;
            up_tc     <= 3'h0; // RL21
            for (int w = NUM_WIN - 1; w >= 0; w--) begin
                if (up_valid && wctl_r[w][3:WIN_EN_LO] != 3'h0
                    && up_addr >= wbase_r[w] && up_addr <= wlim_r[w]) // RL26
                    up_tc <= {2'b00, wctl_r[w][WIN_TC_BIT]}; // RL22
            end
        end
    end
    assign up_vc = 3'h0; // RL25

    // bus clock domain
    logic [1:0]  prst_r;
    logic [SYNW-1:0] cfg_s1_r;
    logic [SYNW-1:0] cfg_s2_r;
    logic [3:0]  itab_r [NUM_PHASE];
    logic        tgl_seen_r;
    logic [5:0]  amask_r;
    logic [6:0]  phase_r;
    logic [7:0]  pre_r;
    logic [4:0]  cnt_r;
    logic [2:0]  own_r;
    logic [2:0]  rr_r;
    logic [6:0]  gnt_r;
    ppa_st_e     st_r;
    logic [6:0]  req_v;
    logic        cand_ok;
    logic [2:0]  cand;
    logic [3:0]  ph_port;
    logic        ph_tick;

    wire prstn = prst_r[1];
    wire [SYNW-1:0] cfg_src = {ld_tgl_r, iso_r[ISO_PREEMP_BIT],
                               iso_r[ISO_TIMED_BIT] && sel_r == SEL_WRR128,
                               mask_r, classic_r};

    always_ff @(posedge pci_clk or negedge rstn) begin
        if (!rstn) prst_r <= 2'b00;
        else       prst_r <= {prst_r[0], 1'b1};
    end

    always_ff @(posedge pci_clk or negedge prstn) begin
        if (!prstn) begin
            cfg_s1_r <= '0;
            cfg_s2_r <= '0;
        end else begin
            cfg_s1_r <= cfg_src;
            cfg_s2_r <= cfg_s1_r;
        end
    end

    wire [6:0] tier_hi = cfg_s2_r[6:0];
    wire       park    = cfg_s2_r[CLS_PARK_BIT];
    wire [5:0] umask   = cfg_s2_r[13:8];
    wire       auto_en = cfg_s2_r[8 + MSK_AUTO_BIT];
    wire       watch   = cfg_s2_r[8 + MSK_WATCH_BIT];
    wire       timed   = cfg_s2_r[16]; // RL1 RL17
    wire       preemp  = timed && cfg_s2_r[17]; // RL19
    wire       ld_tgl  = cfg_s2_r[18];

    // working table, loaded on the toggle from the register side
    always_ff @(posedge pci_clk or negedge prstn) begin
        if (!prstn) begin
            for (int k = 0; k < NUM_PHASE; k++) itab_r[k] <= 4'h0;
            tgl_seen_r <= 1'b0;
        end else if (ld_tgl ^ tgl_seen_r) begin
            for (int k = 0; k < NUM_PHASE; k++)
                itab_r[k] <= stab_r[k / 8][4 * (k % 8) +: 4]; // RL10 RL11
            tgl_seen_r <= ld_tgl;
        end
    end

    // phase stepping
    always_ff @(posedge pci_clk or negedge prstn) begin
        if (!prstn) begin
            pre_r   <= 8'h0;
            phase_r <= 7'h0;
        end else if (!timed) begin
            pre_r   <= 8'h0;
            phase_r <= 7'h0;
        end else if (ph_tick) begin
            pre_r   <= 8'h0;
            phase_r <= phase_r + 7'h1; // RL9
        end else begin
            pre_r   <= pre_r + 8'h1;
        end
    end
    assign ph_tick = timed && pre_r == 8'(PHASE_LEN - 1);
    assign ph_port = itab_r[phase_r]; // RL10

    assign req_v = {~ext_req_n & ~umask & ~amask_r, int_req}; // RL5 RL7

    // candidate selection
    always_comb begin
        cand_ok = 1'b0;
        cand    = 3'h0;
        if (timed) begin
            if (ph_port <= 4'h6 && req_v[ph_port[2:0]]) begin // RL15 RL14
                cand_ok = 1'b1;
                cand    = ph_port[2:0];
            end
        end else if (|(req_v & tier_hi)) begin // RL3
            for (int i = 6; i >= 0; i--) begin
                if (req_v[i] && tier_hi[i]) begin
                    cand_ok = 1'b1;
                    cand    = 3'(i);
                end
            end
        end else begin
            for (int j = 7; j >= 1; j--) begin
                if (req_v[(32'(rr_r) + j) % 7]) begin
                    cand_ok = 1'b1;
                    cand    = 3'((32'(rr_r) + j) % 7);
                end
            end
        end
    end

    wire preempt_hit = preemp && ph_tick && ph_port <= 4'h6
                       && ph_port[2:0] != own_r
                       && req_v[ph_port[2:0]]; // RL19

    // grant state machine
    always_ff @(posedge pci_clk or negedge prstn) begin
        if (!prstn) begin
            st_r    <= ST_IDLE;
            gnt_r   <= 7'h0;
            own_r   <= 3'h0;
            rr_r    <= 3'h0;
            cnt_r   <= 5'h0;
            bk_r    <= 7'h0;
            amask_r <= 6'h0;
        end else begin
            bk_r[6] <= tgl_seen_r;
            if (!watch) bk_r[5:0] <= 6'h0;
            if (!auto_en) amask_r <= 6'h0; // RL7
            case (st_r)
                ST_IDLE: begin
                    cnt_r <= 5'h0;
                    if (cand_ok && frame_n && irdy_n) begin
                        own_r <= cand;
                        rr_r  <= cand;
                        gnt_r <= 7'(1) << cand;
                        st_r  <= ST_GRANT;
                    end else begin
                        gnt_r <= park ? 7'h01 : 7'h00; // RL4
                    end
                end
                ST_GRANT: begin
                    cnt_r <= cnt_r + 5'h1;
                    if (!frame_n) begin
                        st_r <= ST_BUSY;
                    end else if (!req_v[own_r]) begin
                        gnt_r <= 7'h0;
                        st_r  <= ST_IDLE;
                    end else if (cnt_r == 5'(NO_RESP_CLKS - 1)) begin
                        if (own_r != 3'h0) begin
                            if (watch)
                                bk_r[own_r - 3'h1] <= 1'b1; // RL6 RL8
                            if (auto_en)
                                amask_r[own_r - 3'h1] <= 1'b1; // RL7
                        end
                        gnt_r <= 7'h0;
                        st_r  <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    if (preempt_hit) begin
                        gnt_r <= 7'h0; // RL19
                        st_r  <= ST_STOP;
                    end else if (frame_n) begin
                        gnt_r <= 7'h0;
                        st_r  <= ST_IDLE;
                    end
                end
                ST_STOP: begin
                    if (frame_n && irdy_n) st_r <= ST_IDLE;
                end
                default: begin
                    gnt_r <= 7'h0;
                    st_r  <= ST_IDLE;
                end
            endcase
        end
    end

    assign int_gnt   = gnt_r[0];
    assign ext_gnt_n = ~gnt_r[6:1];
endmodule

// >>> bench/ppa_arbiter_sva.sv
// port checker for the secondary bus arbiter
// assumes bind onto ppa_arbiter; clk and pci_clk domains
`timescale 1ns/1ps
module ppa_arbiter_sva
    import ppa_pkg::*;
#(
    parameter int PHASE_LEN = PHASE_CLKS
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        pci_clk,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        int_gnt,
    input wire logic [5:0]  ext_req_n,
    input wire logic [5:0]  ext_gnt_n,
    input wire logic        frame_n,
    input wire logic        irdy_n,
    input wire logic        up_valid,
    input wire logic        up_tvalid,
    input wire logic [2:0]  up_tc,
    input wire logic [2:0]  up_vc
);
    logic [4:0] hold_cnt_r;
    logic [5:0] gnt_q_r;
    // idle clocks of one unchanged external grant
    always_ff @(posedge pci_clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt_r <= 5'h0;
            gnt_q_r    <= 6'h3f;
        end else begin
            gnt_q_r <= ext_gnt_n;
            if (ext_gnt_n == 6'h3f || !frame_n || ext_gnt_n != gnt_q_r) begin
                hold_cnt_r <= 5'h0;
            end else begin
                hold_cnt_r <= hold_cnt_r + 5'h1;
            end
        end
    end
    sequence s_rd_ans;
        ##1 reg_rvalid;
    endsequence
    sequence s_tag_ans;
        ##1 up_tvalid;
    endsequence
    rd_answer_a: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd |-> s_rd_ans) else $error("read not answered");
    rd_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
    tag_answer_a: assert property (@(posedge clk) disable iff (!rstn)
        up_valid |-> s_tag_ans) else $error("class not answered");
    tag_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        !up_valid |=> !up_tvalid) else $error("class without access");
    tc_field_a: assert property (@(posedge clk) disable iff (!rstn)
        up_tvalid |-> up_tc[2:1] == 2'h0) else $error("class too wide");
    vc_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        up_vc == 3'h0) else $error("channel not zero");
    one_owner_a: assert property (@(posedge pci_clk) disable iff (!rstn)
        $onehot0({int_gnt, ~ext_gnt_n})) else $error("two grants");
    grant_req_a: assert property (@(posedge pci_clk) disable iff (!rstn)
        ($past(ext_gnt_n) & ~ext_gnt_n & $past(ext_req_n)) == 6'h0)
        else $error("grant without request");
    grant_idle_a: assert property (@(posedge pci_clk) disable iff (!rstn)
        (|($past(ext_gnt_n) & ~ext_gnt_n)) |-> $past(frame_n & irdy_n))
        else $error("grant on busy bus");
    grant_bound_a: assert property (@(posedge pci_clk) disable iff (!rstn)
        hold_cnt_r < 5'h10) else $error("grant held past 16 clocks");
endmodule
bind ppa_arbiter ppa_arbiter_sva #(.PHASE_LEN(PHASE_LEN)) u_ppa_arbiter_sva (
    .clk(clk), .rstn(rstn), .pci_clk(pci_clk), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .int_gnt(int_gnt),
    .ext_req_n(ext_req_n), .ext_gnt_n(ext_gnt_n), .frame_n(frame_n),
    .irdy_n(irdy_n), .up_valid(up_valid), .up_tvalid(up_tvalid),
    .up_tc(up_tc), .up_vc(up_vc));

// >>> bench/ppa_bus_masters.sv
// model of six external masters on the secondary bus
// assumes arbiter grants; frame and irdy idle high
`timescale 1ns/1ps
module ppa_bus_masters (
    input  wire logic       pci_clk,
    input  wire logic [5:0] want,
    input  wire logic [5:0] silent,
    input  wire logic [5:0] slow,
    input  wire logic [5:0] ext_gnt_n,
    output logic      [5:0] ext_req_n,
    output logic            frame_n,
    output logic            irdy_n
);
    int ph, own, wt;
    initial begin
        ext_req_n = 6'h3f;
        frame_n   = 1'b1;
        irdy_n    = 1'b1;
    end
    always @(posedge pci_clk) begin
        case (ph)
            0: begin
                ext_req_n <= ~want;
                for (int i = 0; i < 6; i++) begin
                    if (!ext_gnt_n[i] && !ext_req_n[i] && !silent[i]) begin
                        own = i;
                        wt  = slow[i] ? 4 : 0;
                        ph  = 1;
                    end
                end
            end
            1: begin
                if (ext_gnt_n[own]) ph = 0;
                else if (wt > 0) wt--;
                else begin
                    frame_n <= 1'b0;
                    irdy_n  <= 1'b0;
                    ph = 2;
                end
            end
            2: begin
                frame_n <= 1'b1;
                ph = 3;
            end
            default: begin
                irdy_n         <= 1'b1;
                ext_req_n[own] <= 1'b1;
                ph = 0;
            end
        endcase
    end
endmodule

// >>> bench/tb.sv
// self-checking bench for the secondary bus arbiter
// assumes ppa_arbiter, ppa_bus_masters and the bound checker
`timescale 1ns/1ps
module tb;
    import ppa_pkg::*;
    logic        clk, pci_clk, rstn, reg_cfg_sel, reg_wr, reg_rd;
    logic        reg_rvalid, int_req, int_gnt, frame_n, irdy_n;
    logic        up_valid, up_tvalid;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, up_addr, b;
    logic [3:0]  reg_be;
    logic [5:0]  ext_req_n, ext_gnt_n, gprev, want, silent, slow;
    logic [2:0]  up_tc, up_vc;
    logic [63:0] e, rq[$];
    logic [2:0]  tq[$];
    int          failures, n_checks, gcnt[6];
    always #2.5 clk = ~clk;
    always #40 pci_clk = ~pci_clk;
    ppa_arbiter #(.PHASE_LEN(2)) u_ppa_arbiter (
        .clk(clk), .rstn(rstn), .pci_clk(pci_clk), .reg_cfg_sel(reg_cfg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .int_req(int_req), .int_gnt(int_gnt),
        .ext_req_n(ext_req_n), .ext_gnt_n(ext_gnt_n), .frame_n(frame_n),
        .irdy_n(irdy_n), .up_valid(up_valid), .up_addr(up_addr),
        .up_tvalid(up_tvalid), .up_tc(up_tc), .up_vc(up_vc));
    ppa_bus_masters u_ppa_bus_masters (
        .pci_clk(pci_clk), .want(want), .silent(silent), .slow(slow),
        .ext_gnt_n(ext_gnt_n), .ext_req_n(ext_req_n), .frame_n(frame_n),
        .irdy_n(irdy_n));
    task automatic cmp(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic c, input logic w, input logic [11:0] a,
                      input logic [31:0] d, m);
        @(negedge clk);
        reg_cfg_sel = c;
        reg_addr    = a;
        reg_wdata   = d;
        reg_wr      = w;
        reg_rd      = !w;
        if (!w) rq.push_back({m, d & m});
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask
    task automatic tab(input logic [31:0] d);
        for (int k = 0; k < TAB_WORDS; k++)
            rw(1'b1, 1'b1, CFG_TAB_FIRST + 12'(4 * k), d, 0);
    endtask
    task automatic pw(input int n);
        foreach (gcnt[i]) gcnt[i] = 0;
        repeat (n) @(negedge pci_clk);
    endtask
    task automatic up(input logic [31:0] a, input logic [2:0] t);
        @(negedge clk);
        up_valid = 1'b1;
        up_addr  = a;
        tq.push_back(t);
        @(negedge clk);
        up_valid = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1 && rq.size() > 0) begin
            e = rq.pop_front();
            cmp(reg_rdata & e[63:32], e[31:0]);
        end
        if (up_tvalid === 1'b1 && tq.size() > 0)
            cmp({29'h0, up_tc}, {29'h0, tq.pop_front()});
    end
    always @(negedge pci_clk) begin
        for (int i = 0; i < 6; i++)
            if (gprev[i] === 1'b1 && ext_gnt_n[i] === 1'b0) gcnt[i]++;
        gprev = ext_gnt_n;
    end
    initial begin
        #300_000;
        failures++;
        test_done();
    end
    initial begin
        {clk, pci_clk, rstn, reg_cfg_sel, reg_wr, reg_rd} = 6'h0;
        {int_req, up_valid, want, silent, slow} = 20'h0;
        {reg_addr, reg_wdata, up_addr} = 76'h0;
        reg_be = 4'hf;
        void'($urandom(32'h7346));
        repeat (8) @(posedge pci_clk);
        @(negedge clk);
        rstn = 1'b1;
        pw(6);
        cmp({31'h0, int_gnt}, 32'h1);
        rw(1'b1, 1'b0, CFG_CLASSIC, 32'h0000_0081, 32'hffff_ffff);
        rw(1'b0, 1'b0, MEM_ISO_CTRL, ISO_RST, 32'hffff_ffff);
        rw(1'b0, 1'b0, MEM_WIN0_CTRL, 32'h0, 32'hf);
        rw(1'b1, 1'b0, 12'h100, 32'h0, 32'hffff_ffff);
        $display("test reset done");
        int_req = 1'b1;
        {want, slow} = 12'h104;
        pw(30);
        cmp(32'(gcnt[2]), 32'h0);
        int_req = 1'b0;
        pw(30);
        cmp(32'(gcnt[2] > 0), 32'h1);
        $display("test tiers done");
        rw(1'b1, 1'b1, CFG_CLASSIC, 32'h0000_0881, 0);
        pw(3);
        want = 6'h0a;
        pw(40);
        cmp(32'(gcnt[3]), 32'h0);
        cmp(32'(gcnt[1] > 0), 32'h1);
        $display("test mask done");
        rw(1'b1, 1'b1, CFG_CLASSIC, 32'h0000_c081, 0);
        want = 6'h10;
        silent = 6'h10;
        pw(60);
        rw(1'b1, 1'b0, CFG_CLASSIC, 32'h0010_0000, 32'h00ff_0000);
        pw(40);
        cmp(32'(gcnt[4]), 32'h0);
        rw(1'b1, 1'b1, CFG_CLASSIC, 32'h0000_8081, 0);
        pw(40);
        cmp(32'(gcnt[4] > 0), 32'h1);
        rw(1'b1, 1'b1, CFG_CLASSIC, 32'h0000_0081, 0);
        pw(3);
        rw(1'b1, 1'b0, CFG_CLASSIC, 32'h0, 32'h00ff_0000);
        {want, silent} = 12'h0;
        $display("test timeout done");
        tab(32'h2222_2222);
        rw(1'b1, 1'b0, CFG_CH1_DW, 32'h0001_0000, 32'h0001_0000);
        rw(1'b1, 1'b1, CFG_CH1_CTRL, 32'h0009_0000, 0);
        pw(6);
        rw(1'b1, 1'b0, CFG_CH1_DW, 32'h0, 32'h0001_0000);
        rw(1'b1, 1'b0, CFG_CH1_CTRL, 32'h0008_0000, 32'h000f_0000);
        rw(1'b0, 1'b1, MEM_ISO_CTRL, 32'h6, 0);
        tab(32'h1111_1111);
        rw(1'b1, 1'b0, CFG_CH1_DW, 32'h0001_0000, 32'h0001_0000);
        want = 6'h03;
        pw(90);
        cmp(32'(gcnt[0]), 32'h0);
        cmp(32'(gcnt[1] > 0), 32'h1);
        rw(1'b0, 1'b1, MEM_ISO_CTRL, 32'h0, 0);
        want = 6'h0;
        $display("test timed done");
        b = ($urandom() & 32'h7fff_ff00) | 32'h100;
        rw(1'b0, 1'b1, MEM_WIN0_CTRL + MEM_WIN_STRIDE, 32'h3, 0);
        rw(1'b0, 1'b1, MEM_WIN0_BASE + MEM_WIN_STRIDE, b, 0);
        rw(1'b0, 1'b1, MEM_WIN0_LIM + MEM_WIN_STRIDE, b + 32'hfc, 0);
        rw(1'b0, 1'b0, MEM_WIN0_CTRL + MEM_WIN_STRIDE, 32'h3, 32'hf);
        up(b - 32'h4, 3'h0);
        up(b, 3'h1);
        up(b + 32'hfc, 3'h1);
        up(b + 32'h100, 3'h0);
        pw(2);
        $display("test windows done");
        test_done();
    end
endmodule
